// ==== hw/dcc_chan.sv ====
// Purpose: one channel: config word, fifo occupancy, enable and auto disable
// Assumes: one bus beat at most per cycle, fetch and drain never together
// Notes: the fifo is modelled by its fill count only
`include "dcc_consts.svh"
module dcc_chan #(
  parameter int unsigned FIFO_DEPTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic cfg_we_i,
  input wire logic [31:0] wdata_i,
  input wire logic busy_i,
  input wire logic fetch_beat_i,
  input wire logic drain_beat_i,
  input wire logic err_i,
  input wire logic xfer_last_i,
  input wire logic [31:0] src_req_i,
  input wire logic [31:0] src_last_i,
  input wire logic [31:0] dst_req_i,
  input wire logic [31:0] dst_last_i,
  output logic [31:0] cfg_rd_o,
  output logic on_o,
  output logic lock_o,
  output logic want_fetch_o,
  output logic want_drain_o,
  output logic dst_rdy_o,
  output logic fetch_full_o,
  output logic drain_empty_o,
  output logic stop_o,
  output logic tc_irq_o,
  output logic err_irq_o
);
  import dcc_pkg::*;

  dcc_chan_s q, d;
  logic src_per, dst_per, fl_ctl, fl_src, fl_dst, fin_fetch, fin_drain;

  always_comb
  begin
    src_per = 1'b0;
    dst_per = 1'b0;
    fl_ctl = 1'b0;
    fl_src = 1'b0;
    fl_dst = 1'b0;
    case (q.flow)
      `DCC_FL_M2M: fl_ctl = 1'b1;
      `DCC_FL_M2P:
      begin
        fl_ctl = 1'b1;
        dst_per = 1'b1;
      end
      `DCC_FL_P2M:
      begin
        fl_ctl = 1'b1;
        src_per = 1'b1;
      end
      `DCC_FL_P2P:
      begin
        fl_ctl = 1'b1;
        src_per = 1'b1;
        dst_per = 1'b1;
      end
      `DCC_FL_P2P_DST:
      begin
        fl_dst = 1'b1;
        src_per = 1'b1;
        dst_per = 1'b1;
      end
      `DCC_FL_M2P_PER:
      begin
        fl_dst = 1'b1;
        dst_per = 1'b1;
      end
      `DCC_FL_P2M_PER:
      begin
        fl_src = 1'b1;
        src_per = 1'b1;
      end
      default:
      begin
        fl_src = 1'b1;
        src_per = 1'b1;
        dst_per = 1'b1;
      end
    endcase
    // request select fields only matter on the peripheral side
    dst_rdy_o = dst_per ? dst_req_i[q.dst_sel] : 1'b1;
    want_fetch_o = q.on && !q.halt && !q.src_done && !q.pend_off
      && (q.fifo_cnt != `DCC_CNT_W'(FIFO_DEPTH))
      && (src_per ? src_req_i[q.src_sel] : 1'b1);
    // draining goes on under halt so buffered data still leaves
    want_drain_o = q.on && !q.pend_off && (q.fifo_cnt != `DCC_ZERO_CNT) && dst_rdy_o;
    fetch_full_o = q.fifo_cnt == `DCC_CNT_W'(FIFO_DEPTH - 1);
    drain_empty_o = q.fifo_cnt == `DCC_ONE_CNT;
    fin_fetch = fetch_beat_i && (fl_ctl ? xfer_last_i : (fl_src && src_last_i[q.src_sel]));
    // trailing beats after auto disable must not raise a second tc
    fin_drain = drain_beat_i && q.on && ((fl_dst && dst_last_i[q.dst_sel])
      || (q.src_done && drain_empty_o));

    d = q;
    d.tc_irq = 1'b0;
    d.err_irq = 1'b0;
    if (fetch_beat_i)
      d.fifo_cnt = q.fifo_cnt + `DCC_ONE_CNT;
    else if (drain_beat_i)
      d.fifo_cnt = q.fifo_cnt - `DCC_ONE_CNT;
    if (fin_fetch)
      d.src_done = 1'b1;
    if (cfg_we_i)
    begin
      d.halt = wdata_i[`DCC_B_HALT];
      d.lock = wdata_i[`DCC_B_LOCK];
      d.tc_mask = wdata_i[`DCC_B_TCM];
      d.err_mask = wdata_i[`DCC_B_ERRM];
      d.flow = wdata_i[`DCC_F_FLOW];
      d.dst_sel = wdata_i[`DCC_F_DST];
      d.src_sel = wdata_i[`DCC_F_SRC];
      if (wdata_i[`DCC_B_ON])
      begin
        d.on = 1'b1;
        d.src_done = 1'b0;
        d.pend_off = 1'b0;
      end
      else if (q.on)
        d.pend_off = 1'b1;
    end
    // the beat on the bus completes first, then fifo contents are dropped
    if (d.pend_off && !busy_i)
    begin
      d.on = 1'b0;
      d.pend_off = 1'b0;
      d.src_done = 1'b0;
      d.fifo_cnt = `DCC_ZERO_CNT;
    end
    if (fin_drain)
    begin
      d.on = 1'b0;
      d.tc_irq = q.tc_mask;
    end
    if (err_i)
    begin
      d.on = 1'b0;
      d.pend_off = 1'b0;
      d.fifo_cnt = `DCC_ZERO_CNT;
      d.err_irq = q.err_mask;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      q <= '0;
    else
      q <= d;
  end

  always_comb
  begin
    cfg_rd_o = `DCC_ZERO32;
    cfg_rd_o[`DCC_B_HALT] = q.halt;
    cfg_rd_o[`DCC_B_OCC] = q.fifo_cnt != `DCC_ZERO_CNT;
    cfg_rd_o[`DCC_B_LOCK] = q.lock;
    cfg_rd_o[`DCC_B_TCM] = q.tc_mask;
    cfg_rd_o[`DCC_B_ERRM] = q.err_mask;
    cfg_rd_o[`DCC_F_FLOW] = q.flow;
    cfg_rd_o[`DCC_F_DST] = q.dst_sel;
    cfg_rd_o[`DCC_F_SRC] = q.src_sel;
    cfg_rd_o[`DCC_B_ON] = q.on;
  end

  assign on_o = q.on;
  assign lock_o = q.lock;
  assign stop_o = q.pend_off;
  assign tc_irq_o = q.tc_irq;
  assign err_irq_o = q.err_irq;

endmodule // dcc_chan

// ==== hw/dcc_ctrl.sv ====
// Purpose: multi-channel dma config and control with a shared bus sequencer
// Assumes: full word register accesses; one bus master port
// Notes: lowest channel index wins the bus
//
// Notes on behaviour
// - halt ignores new source requests, fifo drains
// - read-only occupied flag shows fifo holds data
// - lock bit requests locked bus transfers
// - cleared tc mask suppresses terminal count interrupt
// - cleared error mask suppresses error interrupt
// - flow field picks transfer type and controller
// - destination request select, unused for memory
// - source request select, unused for memory
// - writing one enables; read shows enable
// - enabled channels also seen in status register
// - clearing enable finishes beat, then flushes fifo
// - completion or error clears channel enable
// - lock held for whole burst until released
// - lock normally covers a single burst only
// - lock may span fetch then drain back-to-back
// - codes four to seven make the peripheral the flow controller
// - global enable makes controller operational
//
// Decided for this implementation: strobed register access and the register offsets.
`include "dcc_consts.svh"
module dcc_ctrl #(
  parameter int unsigned NUM_CH = 8,
  parameter int unsigned FIFO_DEPTH = 4,
  parameter int unsigned BURST_LEN = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [31:0] src_req_i,
  input wire logic [31:0] src_last_i,
  input wire logic [31:0] dst_req_i,
  input wire logic [31:0] dst_last_i,
  input wire logic [NUM_CH-1:0] xfer_last_i,
  output logic bus_req_o,
  output logic bus_lock_o,
  output logic bus_drain_o,
  output logic [`DCC_CH_W-1:0] bus_ch_o,
  input wire logic bus_grant_i,
  input wire logic bus_ready_i,
  input wire logic bus_err_i,
  output logic [NUM_CH-1:0] tc_irq_o,
  output logic [NUM_CH-1:0] err_irq_o
);
  import dcc_pkg::*;

  // ----------------------------------------
  // per-channel wiring
  // ----------------------------------------
  dcc_ctrl_s q, d;
  logic [31:0] cfg_rd [NUM_CH];
  logic [NUM_CH-1:0] cfg_we, on, lock, want_f, want_d, dst_rdy;
  logic [NUM_CH-1:0] full1, empty1, stop, busy, f_beat, d_beat, ch_err;
  logic ch_hit, beat, err_beat, pick_ok, pick_drain, burst_end;
  logic [`DCC_CH_W-1:0] pick;

  // channel pages sit at one config word per page
  assign ch_hit = (reg_addr_i[11:8] == `DCC_OFS_CH_PAGE)
    && (reg_addr_i[4:0] == `DCC_OFS_CH_CFG)
    && (32'(reg_addr_i[7:5]) < NUM_CH);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      assign cfg_we[gi] = reg_we_i && ch_hit && (32'(reg_addr_i[7:5]) == gi);
      assign busy[gi] = (q.state != DCC_IDLE) && (32'(q.ch) == gi);
      assign f_beat[gi] = busy[gi] && (q.state == DCC_FETCH) && beat;
      assign d_beat[gi] = busy[gi] && (q.state == DCC_DRAIN) && beat;
      assign ch_err[gi] = busy[gi] && err_beat;
      dcc_chan #(
        .FIFO_DEPTH(FIFO_DEPTH)
      ) u_chan (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .cfg_we_i(cfg_we[gi]),
        .wdata_i(reg_wdata_i),
        .busy_i(busy[gi]),
        .fetch_beat_i(f_beat[gi]),
        .drain_beat_i(d_beat[gi]),
        .err_i(ch_err[gi]),
        .xfer_last_i(xfer_last_i[gi]),
        .src_req_i(src_req_i),
        .src_last_i(src_last_i),
        .dst_req_i(dst_req_i),
        .dst_last_i(dst_last_i),
        .cfg_rd_o(cfg_rd[gi]),
        .on_o(on[gi]),
        .lock_o(lock[gi]),
        .want_fetch_o(want_f[gi]),
        .want_drain_o(want_d[gi]),
        .dst_rdy_o(dst_rdy[gi]),
        .fetch_full_o(full1[gi]),
        .drain_empty_o(empty1[gi]),
        .stop_o(stop[gi]),
        .tc_irq_o(tc_irq_o[gi]),
        .err_irq_o(err_irq_o[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // bus beats and channel pick
  // ----------------------------------------
  // an error response ends the beat as well as ready does
  assign beat = bus_grant_i && bus_ready_i && !bus_err_i;
  assign err_beat = bus_grant_i && bus_err_i;

  always_comb
  begin
    pick_ok = 1'b0;
    pick_drain = 1'b0;
    pick = '0;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (want_f[i] || want_d[i])
      begin
        pick_ok = 1'b1;
        pick_drain = want_d[i];
        pick = `DCC_CH_W'(i);
      end
    end
  end

  // ----------------------------------------
  // sequencer and register port
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.rdata = `DCC_ZERO32;
    burst_end = 1'b0;
    case (q.state)
      DCC_IDLE:
      begin
        // no new burst starts while the controller is globally off
        if (q.ctrl_en && pick_ok)
        begin
          d.state = pick_drain ? DCC_DRAIN : DCC_FETCH;
          d.ch = pick;
          d.beat = `DCC_ZERO_CNT;
        end
      end
      DCC_FETCH:
      begin
        if (err_beat)
          d.state = DCC_IDLE;
        else if (beat)
        begin
          d.beat = q.beat + `DCC_ONE_CNT;
          burst_end = (q.beat == `DCC_CNT_W'(BURST_LEN - 1)) || full1[q.ch]
            || stop[q.ch];
        end
        else
          burst_end = !want_f[q.ch];
        if (burst_end)
        begin
          d.beat = `DCC_ZERO_CNT;
          // locked fetch runs straight into the drain when the sink is ready
          if (lock[q.ch] && dst_rdy[q.ch] && !stop[q.ch] && on[q.ch])
            d.state = DCC_DRAIN;
          else
            d.state = DCC_IDLE;
        end
      end
      DCC_DRAIN:
      begin
        if (err_beat)
          d.state = DCC_IDLE;
        else if (beat)
        begin
          d.beat = q.beat + `DCC_ONE_CNT;
          if ((q.beat == `DCC_CNT_W'(BURST_LEN - 1)) || empty1[q.ch] || stop[q.ch])
            d.state = DCC_IDLE;
        end
        else if (!want_d[q.ch])
          d.state = DCC_IDLE;
      end
      default: d.state = DCC_IDLE;
    endcase

    if (reg_we_i && (reg_addr_i == `DCC_OFS_CTRL_CFG))
      d.ctrl_en = reg_wdata_i[`DCC_B_CTRL_EN];
    if (reg_re_i)
    begin
      if (reg_addr_i == `DCC_OFS_CTRL_CFG)
        d.rdata[`DCC_B_CTRL_EN] = q.ctrl_en;
      else if (reg_addr_i == `DCC_OFS_ENBL_CHNS)
        d.rdata[NUM_CH-1:0] = on;
      else if (ch_hit)
        d.rdata = cfg_rd[reg_addr_i[7:5]];
      else
        d.rdata = `DCC_ZERO32;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      q <= '0;
    else
      q <= d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata_o = q.rdata;
  assign bus_req_o = q.state != DCC_IDLE;
  // lock stays up from the first request cycle to the last beat of the burst
  assign bus_lock_o = (q.state != DCC_IDLE) && lock[q.ch];
  assign bus_drain_o = q.state == DCC_DRAIN;
  assign bus_ch_o = q.ch;

endmodule // dcc_ctrl

// ==== shared/dcc_consts.svh ====
// Purpose: named offsets, field positions and codes of the channel config block
// Assumes: included by the package and the design files
// Notes: byte addresses on the register port
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DCC_OFS_CTRL_CFG 12'h030
`define DCC_OFS_ENBL_CHNS 12'h01C
`define DCC_OFS_CH_PAGE 4'h1
`define DCC_OFS_CH_CFG 5'h10

// ----------------------------------------
// channel_configuration fields
// ----------------------------------------
`define DCC_B_ON 0
`define DCC_F_SRC 5:1
`define DCC_F_DST 10:6
`define DCC_F_FLOW 13:11
`define DCC_B_ERRM 14
`define DCC_B_TCM 15
`define DCC_B_LOCK 16
`define DCC_B_OCC 17
`define DCC_B_HALT 18
`define DCC_B_CTRL_EN 0

// ----------------------------------------
// transfer_flow_select codes
// ----------------------------------------
`define DCC_FL_M2M 3'h0
`define DCC_FL_M2P 3'h1
`define DCC_FL_P2M 3'h2
`define DCC_FL_P2P 3'h3
`define DCC_FL_P2P_DST 3'h4
`define DCC_FL_M2P_PER 3'h5
`define DCC_FL_P2M_PER 3'h6
`define DCC_FL_P2P_SRC 3'h7

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define DCC_CNT_W 8
`define DCC_CH_W 3
`define DCC_ZERO32 32'h0000_0000
`define DCC_ONE_CNT 8'h01
`define DCC_ZERO_CNT 8'h00

`endif

// ==== shared/dcc_pkg.sv ====
// Purpose: types shared by the channel config block
// Assumes: dcc_consts.svh on the include path
// Notes: state encodings are gray along idle, fetch, drain
`include "dcc_consts.svh"
package dcc_pkg;

  typedef enum logic [1:0] {
    DCC_IDLE = 2'b00,
    DCC_FETCH = 2'b01,
    DCC_DRAIN = 2'b11
  } dcc_state_e;

  typedef struct packed {
    logic halt;
    logic lock;
    logic tc_mask;
    logic err_mask;
    logic [2:0] flow;
    logic [4:0] dst_sel;
    logic [4:0] src_sel;
    logic on;
    logic [`DCC_CNT_W-1:0] fifo_cnt;
    logic src_done;
    logic pend_off;
    logic tc_irq;
    logic err_irq;
  } dcc_chan_s;

  typedef struct packed {
    dcc_state_e state;
    logic [`DCC_CH_W-1:0] ch;
    logic [`DCC_CNT_W-1:0] beat;
    logic ctrl_en;
    logic [31:0] rdata;
  } dcc_ctrl_s;

endpackage

// ==== sim/dcc_bus_model.sv ====
// Purpose: arbiter and memory side of the bus link
// Assumes: one master, always granted on request
// Notes: slow mode answers every other cycle
module dcc_bus_model (
  input wire logic clk_sys_i,
  input wire logic bus_req_i,
  input wire logic slow_i,
  input wire logic err_on_i,
  output logic grant_o,
  output logic ready_o,
  output logic err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tgl_q = 1'b0;
  always @(posedge clk_sys_i)
    tgl_q <= ~tgl_q;
  // grant never drops while a burst or its lock stands
  assign grant_o = bus_req_i;
  // idle cycles show no answer
  assign ready_o = bus_req_i & (~slow_i | tgl_q);
  assign err_o = bus_req_i & err_on_i;
endmodule // dcc_bus_model

// ==== sim/dcc_ctrl_asserts.sv ====
// Purpose: port checker of the channel config block
// Assumes: one clock, synchronous active-low reset
// Notes: sees only the top ports, bound below
`include "dcc_consts.svh"
module dcc_ctrl_chk #(
  parameter int unsigned NUM_CH = 8,
  parameter int unsigned FIFO_DEPTH = 4,
  parameter int unsigned BURST_LEN = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic bus_req_o,
  input wire logic bus_lock_o,
  input wire logic bus_drain_o,
  input wire logic bus_grant_i,
  input wire logic bus_ready_i,
  input wire logic bus_err_i,
  input wire logic [NUM_CH-1:0] tc_irq_o,
  input wire logic [NUM_CH-1:0] err_irq_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  // ----
  // helpers
  // ----
  // a fetch running straight into a drain restarts the beat count
  logic [7:0] beats_q;
  logic drn_q;
  logic en_q;
  wire beat = bus_req_o & bus_grant_i & bus_ready_i & ~bus_err_i;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i || !bus_req_o || bus_drain_o != drn_q)
      beats_q <= {7'h00, beat};
    else
      beats_q <= beats_q + {7'h00, beat};
    drn_q <= bus_drain_o;
    if (!rst_b_i)
      en_q <= 1'b0;
    else if (reg_we_i && reg_addr_i == `DCC_OFS_CTRL_CFG)
      en_q <= reg_wdata_i[`DCC_B_CTRL_EN];
  end
  // ----
  // assertions
  // ----
  a_lock_in_burst: assert property (bus_lock_o |-> bus_req_o)
    else $error("lock outside a burst");
  a_burst_len_cap: assert property (beats_q <= BURST_LEN)
    else $error("burst longer than its length");
  a_lock_ends_idle: assert property ($fell(bus_req_o) |-> !bus_lock_o)
    else $error("lock held past burst end");
  a_lock_spans_two: assert property (
    bus_req_o && $past(bus_req_o) && $rose(bus_drain_o) |-> bus_lock_o && $past(bus_lock_o))
    else $error("direct drain without lock");
  a_tc_one_pulse: assert property (tc_irq_o != '0 |=> tc_irq_o == '0)
    else $error("tc pulse too long");
  a_err_has_cause: assert property (
    $rose(|err_irq_o) |-> $past(bus_err_i) || $past(bus_err_i, 2))
    else $error("error pulse without bus error");
  a_err_ends_burst: assert property (
    bus_req_o && bus_grant_i && bus_err_i |=> !bus_req_o)
    else $error("burst runs on after error");
  a_ctrl_gates_run: assert property ($rose(bus_req_o) |-> $past(en_q))
    else $error("burst started while disabled");
  a_status_hi_zero: assert property (
    reg_re_i && reg_addr_i == `DCC_OFS_ENBL_CHNS |=> reg_rdata_o[31:NUM_CH] == '0)
    else $error("status upper bits set");
  c_direct_drain: cover property (bus_req_o && $past(bus_req_o) && $rose(bus_drain_o));
  c_tc_pulse: cover property (tc_irq_o != '0);
  c_err_pulse: cover property (err_irq_o != '0);
endmodule // dcc_ctrl_chk

bind dcc_ctrl dcc_ctrl_chk #(.NUM_CH(NUM_CH), .FIFO_DEPTH(FIFO_DEPTH), .BURST_LEN(BURST_LEN))
  u_dcc_ctrl_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .bus_req_o(bus_req_o), .bus_lock_o(bus_lock_o),
  .bus_drain_o(bus_drain_o), .bus_grant_i(bus_grant_i), .bus_ready_i(bus_ready_i),
  .bus_err_i(bus_err_i), .tc_irq_o(tc_irq_o), .err_irq_o(err_irq_o));

// ==== sim/dcc_ctrl_test.sv ====
// Purpose: self-checking bench of the channel config block
// Assumes: dcc_pkg and consts compiled first
// Notes: peripheral lines driven here, bus by the model
`include "dcc_consts.svh"
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) \
    begin \
      num_errors++; \
      $display("wrong value %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module dcc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [31:0] src_req_i = 32'h0000_0000;
  logic [31:0] dst_req_i = 32'h0000_0000;
  logic [7:0] xfer_last_i = 8'h00;
  logic [31:0] src_last_i = 32'h0000_0000;
  logic [31:0] dst_last_i = 32'h0000_0000;
  logic slow = 1'b0;
  logic err_on = 1'b0;
  logic [31:0] reg_rdata_o;
  logic bus_req_o, bus_lock_o, bus_drain_o, bus_grant_i, bus_ready_i, bus_err_i;
  logic [7:0] tc_irq_o, err_irq_o;
  logic [2:0] bus_ch;
  logic req_q = 1'b0;
  int num_errors = 0;
  int checks_done = 0;
  int n_tc = 0;
  int n_err = 0;
  int n_fetch = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  dcc_ctrl u_dcc_ctrl (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .src_req_i(src_req_i), .src_last_i(src_last_i),
    .dst_req_i(dst_req_i), .dst_last_i(dst_last_i), .xfer_last_i(xfer_last_i),
    .bus_req_o(bus_req_o), .bus_lock_o(bus_lock_o), .bus_drain_o(bus_drain_o),
    .bus_ch_o(bus_ch), .bus_grant_i(bus_grant_i), .bus_ready_i(bus_ready_i),
    .bus_err_i(bus_err_i), .tc_irq_o(tc_irq_o), .err_irq_o(err_irq_o));
  dcc_bus_model u_dcc_bus_model (.clk_sys_i(clk_sys_i), .bus_req_i(bus_req_o),
    .slow_i(slow), .err_on_i(err_on), .grant_o(bus_grant_i), .ready_o(bus_ready_i),
    .err_o(bus_err_i));
  always @(posedge clk_sys_i)
  begin
    if (tc_irq_o != 8'h00)
      n_tc++;
    if (err_irq_o != 8'h00)
      n_err++;
    if (bus_req_o && !req_q && !bus_drain_o)
      n_fetch++;
    req_q <= bus_req_o;
  end
  // ----
  // bus tasks
  // ----
  function automatic logic [11:0] cfg(input logic [2:0] c);
    return {`DCC_OFS_CH_PAGE, c, `DCC_OFS_CH_CFG};
  endfunction
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask
  // whole words only
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // ----
  // scenarios
  // ----
  task automatic s_reset();
    logic [31:0] v;
    for (int i = 0; i < 8; i++)
    begin
      rd(cfg(3'(i)), v);
      `CHK("cfg reset", 32'h0000_0000, v)
    end
    rd(`DCC_OFS_ENBL_CHNS, v);
    `CHK("status reset", 32'h0000_0000, v)
    rd(12'h3FC, v);
    `CHK("unmapped", 32'h0000_0000, v)
  endtask
  task automatic s_fields();
    logic [31:0] v;
    for (int f = 0; f < 8; f++)
    begin
      wr(cfg(1), 32'hFFFF_C7FE | (f << 11));
      rd(cfg(1), v);
      `CHK("fields", 32'h0005_C7FE | (f << 11), v)
    end
    wr(cfg(1), 32'h0000_0000);
  endtask
  task automatic s_run_masked();
    logic [31:0] v;
    int t0;
    t0 = n_tc;
    wr(cfg(0), 32'h0000_0001);
    repeat (20) tick();
    `CHK("start while off", 0, n_fetch)
    rd(`DCC_OFS_ENBL_CHNS, v);
    `CHK("status on", 32'h0000_0001, v)
    wr(`DCC_OFS_CTRL_CFG, 32'h0000_0001);
    repeat (30) if (bus_req_o !== 1'b1) tick();
    `CHK("run", 1'b1, bus_req_o)
    @(posedge clk_sys_i);
    xfer_last_i <= 8'h01;
    v = 32'h0000_0001;
    repeat (30) if (v[0] !== 1'b0) rd(cfg(0), v);
    `CHK("auto off", 32'h0000_0000, v)
    `CHK("tc masked", t0, n_tc)
  endtask
  task automatic s_locked();
    logic [31:0] v;
    int t0;
    t0 = n_tc;
    @(posedge clk_sys_i);
    slow <= 1'b1;
    wr(cfg(0), 32'h0001_8001);
    repeat (30) if (bus_req_o !== 1'b1) tick();
    `CHK("lock", 1'b1, bus_lock_o)
    // req_q holds the request of the cycle before the drain began
    repeat (30) if (bus_drain_o !== 1'b1) tick();
    `CHK("locked drain", 2'b11, {req_q, bus_lock_o})
    repeat (80) if (n_tc == t0) tick();
    `CHK("tc", t0 + 1, n_tc)
    rd(cfg(0), v);
    `CHK("done off", 32'h0001_8000, v)
    slow <= 1'b0;
  endtask
  task automatic s_error();
    logic [31:0] v;
    int e0;
    for (int m = 0; m < 2; m++)
    begin
      e0 = n_err;
      @(posedge clk_sys_i);
      err_on <= 1'b1;
      wr(cfg(0), 32'h0000_0001 | (m << 14));
      repeat (40) tick();
      rd(cfg(0), v);
      `CHK("err off", 32'h0000_0000 | (m << 14), v)
      `CHK("err irq", e0 + m, n_err)
    end
    err_on <= 1'b0;
  endtask
  task automatic fill(input logic [2:0] c);
    wr(cfg(c), 32'h0000_198B);
    repeat (30) if (bus_req_o !== 1'b1) tick();
    `CHK("owner", c, bus_ch)
    repeat (40) tick();
  endtask
  task automatic s_per_flow();
    logic [31:0] v;
    int t0;
    t0 = n_tc;
    @(posedge clk_sys_i);
    src_last_i[5] <= 1'b1;
    wr(cfg(4), 32'h0000_B98B);
    v = 32'h0000_0001;
    repeat (30) if (v[0] !== 1'b0) rd(cfg(4), v);
    `CHK("src flow end", 32'h0000_B98A, v)
    `CHK("src flow tc", t0 + 1, n_tc)
    @(posedge clk_sys_i);
    src_last_i[5] <= 1'b0;
    dst_last_i[6] <= 1'b1;
    wr(cfg(4), 32'h0000_A18B);
    v = 32'h0000_0001;
    repeat (30) if (v[0] !== 1'b0) rd(cfg(4), v);
    // the running drain burst empties the fifo after the auto disable
    repeat (10) tick();
    rd(cfg(4), v);
    `CHK("dst flow end", 32'h0000_A18A, v)
    `CHK("dst flow tc", t0 + 2, n_tc)
    @(posedge clk_sys_i);
    dst_last_i[6] <= 1'b0;
  endtask
  task automatic s_halt();
    logic [31:0] v;
    int f0;
    @(posedge clk_sys_i);
    src_req_i[5] <= 1'b1;
    dst_req_i[7] <= 1'b1;
    fill(3'h2);
    rd(cfg(2), v);
    `CHK("occupied", 32'h0002_198B, v)
    wr(cfg(2), 32'h0004_198B);
    @(posedge clk_sys_i);
    dst_req_i[6] <= 1'b1;
    repeat (30) if (v[17] !== 1'b0) rd(cfg(2), v);
    `CHK("drained", 32'h0004_198B, v)
    f0 = n_fetch;
    repeat (30) tick();
    `CHK("halted", f0, n_fetch)
    wr(cfg(2), 32'h0004_198A);
  endtask
  task automatic s_drop();
    logic [31:0] v;
    @(posedge clk_sys_i);
    dst_req_i[6] <= 1'b0;
    fill(3'h3);
    wr(cfg(3), 32'h0000_198A);
    rd(cfg(3), v);
    `CHK("flushed", 32'h0000_198A, v)
    rd(`DCC_OFS_ENBL_CHNS, v);
    `CHK("all off", 32'h0000_0000, v)
    wr(`DCC_OFS_CTRL_CFG, 32'h0000_0000);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    s_reset();
    s_fields();
    s_run_masked();
    s_locked();
    s_error();
    s_halt();
    s_per_flow();
    s_drop();
    summarize();
  end
  // the whole run takes under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    summarize();
  end
endmodule // dcc_ctrl_test
